// ---- dv/ebprb_asserts.sv ----
// Port-level assertions for the pin routing block.
// Assumes it is bound into ebprb_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ebprb_asserts
  import ebprb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic io_cs,
  input wire logic io_we,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic loader_handoff,
  input wire logic ext_mem_clk_en,
  input wire logic boot_strap_done,
  input wire logic [4:0] ext_addr_width,
  input wire logic sdram_usable,
  input wire logic [5:0] ext_mem_addr_pins_in,
  input wire logic [5:0] ext_mem_addr_pins_out,
  input wire logic [5:0] ext_mem_addr_pins_oe,
  input wire logic [5:0] external_memory_if_addr_hi,
  input wire logic [5:0] upper_gpio_out,
  input wire logic [5:0] upper_gpio_oe,
  input wire ebprb_pp_sig_t pp_periph_out,
  input wire logic [27:0] pp_pin_out,
  input wire ebprb_sp1_sig_t sp1_periph_out,
  input wire logic [5:0] sp1_pin_out,
  input wire ebprb_sp0_sig_t sp0_periph_out,
  input wire logic [5:0] sp0_pin_out
);
  logic [4:0] rel_r;
  logic [5:0] strap_r;
  logic wr_sel, rd_sel, rd_boot;
  assign wr_sel = io_cs && io_we && io_addr == EBPRB_SEL_ADDR;
  assign rd_sel = io_cs && !io_we && io_addr == EBPRB_SEL_ADDR;
  assign rd_boot = io_cs && !io_we && io_addr == EBPRB_BOOT_ADDR;
  // Edges since release, pin copy at edge ten
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rel_r <= 5'h00;
      strap_r <= 6'h00;
    end else begin
      if (rel_r != 5'h1F) begin
        rel_r <= rel_r + 5'h01;
      end
      if (rel_r == 5'h09) begin
        strap_r <= ext_mem_addr_pins_in;
      end
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_strap_edge: assert property (boot_strap_done == (rel_r >= 5'h0A))
    else $error("strap capture at wrong edge");
  a_upper_hold: assert property (!boot_strap_done |-> ext_mem_addr_pins_oe == 6'h00)
    else $error("upper pins driven before capture");
  a_strap_read: assert property (rd_boot && boot_strap_done |=> io_rdata == {10'h000, strap_r})
    else $error("strap read value wrong");
  a_rsvd_zero: assert property (rd_sel |=> io_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  a_pin_oe: assert property (wr_sel && boot_strap_done |=>
    ext_mem_addr_pins_oe == (~$past(io_wdata[5:0]) | (upper_gpio_oe & $past(io_wdata[5:0]))))
    else $error("upper pin enable wrong");
  a_pin_drive: assert property (wr_sel && boot_strap_done |=>
    ext_mem_addr_pins_out == ((external_memory_if_addr_hi & ~$past(io_wdata[5:0])) | (upper_gpio_out & $past(io_wdata[5:0]))))
    else $error("upper pin drive wrong");
  a_reach_full: assert property (wr_sel && io_wdata[5:0] == 6'h00 |=> ext_addr_width == 5'h15)
    else $error("full reach wrong");
  a_reach_low: assert property (wr_sel && io_wdata[0] |=> ext_addr_width == 5'h0F)
    else $error("low reach wrong");
  a_clk_off: assert property (loader_handoff |=> !ext_mem_clk_en)
    else $error("memory clock still on");
  a_host_route: assert property (wr_sel && io_wdata[14:12] == 3'h0 |=>
    pp_pin_out == pp_periph_out.host && !sdram_usable)
    else $error("host route wrong");
  a_bsp_clock: assert property (wr_sel && io_wdata[9:8] == 2'h3 |=>
    sp0_pin_out[5] == ($past(io_wdata[15]) ? sp0_periph_out.bsp_sample : sp0_periph_out.bsp[5]))
    else $error("shared clock pin wrong");
  a_sp1_gio: assert property (wr_sel && io_wdata[11:10] == 2'h2 |=> sp1_pin_out == sp1_periph_out.gpio)
    else $error("serial one general route wrong");
endmodule
`default_nettype wire

// ---- dv/ebprb_bench.sv ----
// Self-checking bench for the pin routing block.
// Assumes design, board model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module ebprb_bench
  import ebprb_pkg::*;
;
  logic clk, resetn, io_cs, io_we, loader_handoff, ext_mem_clk_request, ext_mem_clk_en, boot_strap_done, sdram_usable;
  logic [15:0] io_addr, io_wdata, io_rdata;
  logic [4:0] ext_addr_width;
  logic [5:0] strap, ext_mem_addr_pins_in, ext_mem_addr_pins_out, ext_mem_addr_pins_oe, external_memory_if_addr_hi;
  logic [5:0] upper_gpio_out, upper_gpio_oe, upper_gpio_in;
  logic [5:0] sp1_pin_in, sp1_pin_out, sp1_pin_oe, sp0_pin_in, sp0_pin_out, sp0_pin_oe;
  logic [27:0] pp_pin_in, pp_pin_out, pp_pin_oe;
  ebprb_pp_sig_t pp_periph_out, pp_periph_oe, pp_periph_in;
  ebprb_sp1_sig_t sp1_periph_out, sp1_periph_oe, sp1_periph_in;
  ebprb_sp0_sig_t sp0_periph_out, sp0_periph_oe, sp0_periph_in;
  int miscompares, num_checks;

  ebprb_top u_ebprb_top (.clk, .resetn, .io_cs, .io_we, .io_addr, .io_wdata, .io_rdata, .loader_handoff,
    .ext_mem_clk_request, .ext_mem_clk_en, .boot_strap_done, .ext_addr_width, .sdram_usable, .ext_mem_addr_pins_in,
    .ext_mem_addr_pins_out, .ext_mem_addr_pins_oe, .external_memory_if_addr_hi, .upper_gpio_out, .upper_gpio_oe, .upper_gpio_in,
    .pp_periph_out, .pp_periph_oe, .pp_periph_in, .pp_pin_in, .pp_pin_out, .pp_pin_oe, .sp1_periph_out,
    .sp1_periph_oe, .sp1_periph_in, .sp1_pin_in, .sp1_pin_out, .sp1_pin_oe, .sp0_periph_out, .sp0_periph_oe,
    .sp0_periph_in, .sp0_pin_in, .sp0_pin_out, .sp0_pin_oe);
  ebprb_board u_ebprb_board (.strap, .up_out(ext_mem_addr_pins_out), .up_oe(ext_mem_addr_pins_oe),
    .up_in(ext_mem_addr_pins_in), .pp_out(pp_pin_out), .pp_oe(pp_pin_oe), .pp_in(pp_pin_in), .sp1_out(sp1_pin_out),
    .sp1_oe(sp1_pin_oe), .sp1_in(sp1_pin_in), .sp0_out(sp0_pin_out), .sp0_oe(sp0_pin_oe), .sp0_in(sp0_pin_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk28(input string nm, input logic [27:0] e, input logic [27:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One access, taken at the next edge
  task automatic io_acc(input logic we, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    io_cs = 1'b1;
    io_we = we;
    io_addr = a;
    io_wdata = d;
    @(posedge clk);
    #1;
    io_cs = 1'b0;
  endtask
  task automatic io_read(input logic [15:0] a, input logic [15:0] e, input string nm);
    io_acc(1'b0, a, 16'h0000);
    chk16(nm, e, io_rdata);
  endtask

  task automatic boot(input logic [5:0] s);
    int n;
    strap = s;
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    n = 0;
    while (boot_strap_done !== 1'b1 && n < 20) begin
      chk16("upper pins", {4'h0, s, 6'h00}, {4'h0, upper_gpio_in, ext_mem_addr_pins_oe});
      @(posedge clk);
      #1 n++;
    end
    chk16("strap edges", 16'h000A, n[15:0]);
    chk16("mem clock reset", 16'h0001, {15'h0000, ext_mem_clk_en});
    io_read(EBPRB_BOOT_ADDR, {10'h000, s}, "strap reg");
    io_read(EBPRB_SEL_ADDR, 16'h103F, "select reset");
  endtask

  function automatic logic [27:0] exp_pp(input logic [2:0] m);
    case (m)
      3'h0: return pp_periph_out.host;
      3'h1: return {pp_periph_out.sdram, pp_periph_out.aud2, pp_periph_out.uart, pp_periph_out.gpio[5:0],
        pp_periph_out.spi};
      3'h2: return {pp_periph_out.sdram, 13'h0000, pp_periph_out.gpio};
      3'h3: return {pp_periph_out.sdram, 13'h0000, pp_periph_out.aud3, pp_periph_out.spi[3:0]};
      3'h4: return {pp_periph_out.sdram, 13'h0000, pp_periph_out.uart, pp_periph_out.aud2};
      3'h5: return {pp_periph_out.sdram, 13'h0000, pp_periph_out.uart, pp_periph_out.spi[3:0]};
      default: return {pp_periph_out.sdram, pp_periph_out.aud3, pp_periph_out.aud2, pp_periph_out.gpio[5:0],
        pp_periph_out.spi};
    endcase
  endfunction
  function automatic logic [11:0] exp_ser(input logic [2:0] k);
    logic [5:0] s0;
    logic [5:0] s1;
    case (k[1:0])
      2'h0: s0 = sp0_periph_out.card;
      2'h1: s0 = {sp0_periph_out.gpio[5:4], sp0_periph_out.aud0};
      2'h2: s0 = sp0_periph_out.gpio;
      default: s0 = {k[2] ? sp0_periph_out.bsp_sample : sp0_periph_out.bsp[5], sp0_periph_out.bsp[4:0]};
    endcase
    s1 = k[1:0] == 2'h0 ? sp1_periph_out.card : (k[1:0] == 2'h1 ? sp1_periph_out.mspi : sp1_periph_out.gpio);
    return {s1, s0};
  endfunction

  initial begin
    #(2000 * 40);
    miscompares++;
    complete_run();
  end

  initial begin
    logic [5:0] m;
    logic [1:0] c1;
    miscompares = 0;
    num_checks = 0;
    io_cs = 1'b0;
    io_we = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
    loader_handoff = 1'b0;
    ext_mem_clk_request = 1'b0;
    external_memory_if_addr_hi = 6'h15;
    upper_gpio_out = 6'h2B;
    upper_gpio_oe = 6'h0E;
    pp_periph_out = 62'h1A5C3E91B7D46F82;
    pp_periph_oe = 62'h3FFFFFFFFFFFFFFF;
    sp1_periph_out = 18'h2D1B6;
    sp1_periph_oe = 18'h3FFFF;
    sp0_periph_out = 23'h5B3A71;
    sp0_periph_oe = 23'h7FFFFF;
    sp0_periph_out.bsp_sample = ~sp0_periph_out.bsp[5];
    boot(6'h2D);
    io_acc(1'b1, EBPRB_SEL_ADDR, 16'hE9FF);
    io_read(EBPRB_SEL_ADDR, 16'hE93F, "select bits");
    io_acc(1'b1, EBPRB_BOOT_ADDR, 16'hFFFF);
    io_read(EBPRB_BOOT_ADDR, 16'h002D, "strap kept");
    io_read(16'h1C01, 16'h0000, "unmapped");
    for (int i = 0; i < 7; i++) begin
      m = 6'h3F << i;
      io_acc(1'b1, EBPRB_SEL_ADDR, {4'h1, 6'h00, m});
      chk16("address reach", 16'h000F + i[15:0], {11'h000, ext_addr_width});
      chk16("upper enable", {10'h000, ~m | (upper_gpio_oe & m)}, {10'h000, ext_mem_addr_pins_oe});
      chk16("upper drive", {10'h000, (external_memory_if_addr_hi & ~m) | (upper_gpio_out & m)},
        {10'h000, ext_mem_addr_pins_out});
    end
    for (int i = 0; i < 7; i++) begin
      io_acc(1'b1, EBPRB_SEL_ADDR, {1'b0, i[2:0], 12'h03F});
      chk28("parallel pins", exp_pp(i[2:0]), pp_pin_out);
      chk28("parallel enable", i > 1 && i < 6 ? 28'hFE000FF : 28'hFFFFFFF, pp_pin_oe);
      chk16("sdram", {8'h00, i ? pp_periph_out.sdram : 7'h00, i != 0},
        {8'h00, pp_periph_in.sdram, sdram_usable});
    end
    for (int i = 0; i < 8; i++) begin
      c1 = i[1:0] == 2'h3 ? 2'h2 : i[1:0];
      io_acc(1'b1, EBPRB_SEL_ADDR, {i[2], 3'h1, c1, i[1:0], 8'h3F});
      chk28("serial pins", {16'h0FFF, exp_ser(i[2:0])},
        {4'h0, sp1_pin_oe, sp0_pin_oe, sp1_pin_out, sp0_pin_out});
      chk16("serial in", {4'h0, c1 == 2'h2 ? sp1_periph_out.gpio : 6'h00, i[1:0] ? 6'h00 : sp0_periph_out.card},
        {4'h0, sp1_periph_in.gpio, sp0_periph_in.card});
    end
    @(posedge clk);
    #1 loader_handoff = 1'b1;
    ext_mem_clk_request = 1'b1;
    @(posedge clk);
    #1 loader_handoff = 1'b0;
    chk16("mem clock off", 16'h0000, {15'h0000, ext_mem_clk_en});
    @(posedge clk);
    #1 ext_mem_clk_request = 1'b0;
    chk16("mem clock on", 16'h0001, {15'h0000, ext_mem_clk_en});
    boot(6'h12);
    complete_run();
  end
endmodule

bind ebprb_top ebprb_asserts u_ebprb_asserts (.clk, .resetn, .io_cs, .io_we, .io_addr, .io_wdata, .io_rdata,
  .loader_handoff, .ext_mem_clk_en, .boot_strap_done, .ext_addr_width, .sdram_usable, .ext_mem_addr_pins_in,
  .ext_mem_addr_pins_out, .ext_mem_addr_pins_oe, .external_memory_if_addr_hi, .upper_gpio_out, .upper_gpio_oe,
  .pp_periph_out, .pp_pin_out, .sp1_periph_out, .sp1_pin_out, .sp0_periph_out, .sp0_pin_out);
`default_nettype wire

// ---- dv/ebprb_board.sv ----
// Board model: strap pulls on the upper pins, pull-ups on port pins.
// Assumes pin outputs and enables come straight from the routing block.
`timescale 1ns/1ps
`default_nettype none
module ebprb_board (
  input wire logic [5:0] strap,
  input wire logic [5:0] up_out,
  input wire logic [5:0] up_oe,
  output logic [5:0] up_in,
  input wire logic [27:0] pp_out,
  input wire logic [27:0] pp_oe,
  output logic [27:0] pp_in,
  input wire logic [5:0] sp1_out,
  input wire logic [5:0] sp1_oe,
  output logic [5:0] sp1_in,
  input wire logic [5:0] sp0_out,
  input wire logic [5:0] sp0_oe,
  output logic [5:0] sp0_in
);
  assign up_in = (up_out & up_oe) | (strap & ~up_oe);
  assign pp_in = (pp_out & pp_oe) | ~pp_oe;
  assign sp1_in = (sp1_out & sp1_oe) | ~sp1_oe;
  assign sp0_in = (sp0_out & sp0_oe) | ~sp0_oe;
endmodule
`default_nettype wire

// ---- rtl/ebprb_lane_mux.sv ----
// One pin group: picks which source's lanes drive the pins.
// Assumes sources beyond NSRC (reserved codes) leave the pins undriven.
`timescale 1ns/1ps
`default_nettype none
module ebprb_lane_mux #(
  parameter int unsigned W = 6,
  parameter int unsigned NSRC = 4,
  parameter int unsigned SW = 2
) (
  input wire logic [SW-1:0] sel,
  input wire logic [NSRC*W-1:0] lane_out,
  input wire logic [NSRC*W-1:0] lane_oe,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [NSRC*W-1:0] lane_in
);

  genvar k;
  generate
    for (k = 0; k < NSRC; k++) begin : g_src
      // Only the selected source sees the pins
      assign lane_in[k*W +: W] = (sel == SW'(k)) ? pin_in : '0;
    end
  endgenerate

  always_comb begin
    pin_out = '0;
    pin_oe = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (sel == SW'(i)) begin
        pin_out = lane_out[i*W +: W];
        pin_oe = lane_oe[i*W +: W];
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ebprb_pkg.sv ----
// Constants, field layouts and carrier types for the external bus pin routing block.
// Assumes one system clock and an active-low asynchronous reset in every user.
package ebprb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // I/O-space addresses and register images
  localparam logic [15:0] EBPRB_SEL_ADDR = 16'h1C00;
  localparam logic [15:0] EBPRB_BOOT_ADDR = 16'h1C5A;
  localparam logic [15:0] EBPRB_SEL_RESET = 16'h103F;
  // Bits 7:6 are read-only zero
  localparam logic [15:0] EBPRB_SEL_WMASK = 16'hFF3F;
  localparam logic [15:0] EBPRB_BOOT_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the selection register
  localparam int unsigned EBPRB_CLK_CHOICE_POS = 15;
  localparam int unsigned EBPRB_PP_LSB = 12;
  localparam int unsigned EBPRB_SP1_LSB = 10;
  localparam int unsigned EBPRB_SP0_LSB = 8;
  localparam int unsigned EBPRB_ADDR_MODE_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin counts and timing
  localparam int unsigned EBPRB_UPPER_PINS = 6;
  localparam int unsigned EBPRB_PP_PINS = 28;
  localparam int unsigned EBPRB_SP_PINS = 6;
  localparam int unsigned EBPRB_LOW_ADDR_BITS = 15;
  localparam int unsigned EBPRB_SDRAM_ADDR_BITS = 11;
  // System clock cycles from reset release to the strap capture
  localparam logic [3:0] EBPRB_BOOT_LATCH_CYCLES = 4'hA;

  ////////////////////////////////////////////////////////////////////////////
  // Routing modes
  typedef enum logic [2:0] {
    EBPRB_PP_HOST = 3'h0,
    EBPRB_PP_SPI_GIO_UART_AUD2 = 3'h1,
    EBPRB_PP_GIO = 3'h2,
    EBPRB_PP_SPI_AUD3 = 3'h3,
    EBPRB_PP_AUD2_UART = 3'h4,
    EBPRB_PP_SPI_UART = 3'h5,
    EBPRB_PP_SPI_AUD2_AUD3_GIO = 3'h6,
    EBPRB_PP_RSVD = 3'h7
  } ebprb_pp_mode_t;

  typedef enum logic [1:0] {
    EBPRB_SP1_CARD = 2'h0,
    EBPRB_SP1_MSPI = 2'h1,
    EBPRB_SP1_GIO = 2'h2,
    EBPRB_SP1_RSVD = 2'h3
  } ebprb_sp1_mode_t;

  typedef enum logic [1:0] {
    EBPRB_SP0_CARD = 2'h0,
    EBPRB_SP0_AUD0_GIO = 2'h1,
    EBPRB_SP0_GIO = 2'h2,
    EBPRB_SP0_BSP = 2'h3
  } ebprb_sp0_mode_t;

  // Strap capture sequence, Gray along the path
  typedef enum logic [1:0] {
    EBPRB_WAIT = 2'b00,
    EBPRB_CAPTURE = 2'b01,
    EBPRB_RUN = 2'b11
  } ebprb_boot_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers: same shape used for peripheral out, enable and in
  typedef struct packed {
    logic [27:0] host;
    logic [6:0] spi;
    logic [7:0] gpio;
    logic [3:0] uart;
    logic [3:0] aud2;
    logic [3:0] aud3;
    logic [6:0] sdram;
  } ebprb_pp_sig_t;

  typedef struct packed {
    logic [5:0] card;
    logic [5:0] mspi;
    logic [5:0] gpio;
  } ebprb_sp1_sig_t;

  // bsp[5] is the receive clock lane, bsp_sample the sample-rate clock
  typedef struct packed {
    logic [5:0] card;
    logic [3:0] aud0;
    logic [5:0] gpio;
    logic [5:0] bsp;
    logic bsp_sample;
  } ebprb_sp0_sig_t;

  typedef struct packed {
    logic [15:0] sel;
    logic [5:0] strap;
    logic [3:0] cnt;
    ebprb_boot_state_t boot;
    logic mem_clk_en;
    logic [15:0] rdata;
  } ebprb_state_t;

endpackage

// ---- rtl/ebprb_top.sv ----
// Pin routing and boot-strap capture: selection register, three pin groups,
// six upper address/general pins and the strap latch.
// Assumes I/O-space accesses synchronous to clk, peripherals on the other side.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - Upper six pins stay inputs through reset until straps are captured.
// R2 - Ten clocks after reset release the six pin levels are latched, read at 0x1C5A.
// R3 - Loader reads the latched strap value to choose its boot source.
// R4 - Loader writing 0x1C00 switches the upper pins to address outputs.
// R5 - Board must not fight pins driven as address outputs.
// R6 - External memory clock is switched off at loader hand-off.
// R7 - Address reach is 15 bits, 21 with all upper pins as address.
// R8 - NAND and SDRAM need none of the upper pins as address.
// R9 - Selection register routes parallel and both serial pin groups.
// R10 - New routing takes effect on the clock after the write.
// R11 - Each upper pin: select 1 general I/O, 0 address output.
// R12 - Software gates affected peripheral clocks before changing routing.
// R13 - Software resets affected peripherals after changing routing.
// R14 - Bit 15 picks receive or sample clock onto shared pin in mode 3.
// R15 - Parallel code 000 routes all 28 host port signals; SDRAM unusable.
// R16 - Code 001: 7 SPI, 6 general, 4 UART, 4 audio2, 7 SDRAM.
// R17 - Code 010: 8 general I/O and 7 SDRAM control.
// R18 - Code 011: 4 SPI, 4 audio3, 7 SDRAM control.
// R19 - Code 100: 4 audio2, 4 UART, 7 SDRAM control.
// R20 - Code 101: 4 SPI, 4 UART, 7 SDRAM control.
// R21 - Code 110: 7 SPI, audio2, audio3, 6 general, SDRAM; 111 reserved.
// R22 - Reset value: bit15 0, parallel 001, serial 00, upper selects all 1.
// R23 - Serial port 1: card port, multichannel SPI, or general 11:6.
// R24 - Serial port 0: card, audio0 plus general, general, buffered serial port.
// R25 - Bits 7:6 read zero and ignore writes.
// R26 - Reserved codes are never written; their routing is undefined.
module ebprb_top
  import ebprb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic io_cs,
  input wire logic io_we,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic loader_handoff,
  input wire logic ext_mem_clk_request,
  output logic ext_mem_clk_en,
  output logic boot_strap_done,
  output logic [4:0] ext_addr_width,
  output logic sdram_usable,
  input wire logic [5:0] ext_mem_addr_pins_in,
  output logic [5:0] ext_mem_addr_pins_out,
  output logic [5:0] ext_mem_addr_pins_oe,
  input wire logic [5:0] external_memory_if_addr_hi,
  input wire logic [5:0] upper_gpio_out,
  input wire logic [5:0] upper_gpio_oe,
  output logic [5:0] upper_gpio_in,
  input wire ebprb_pp_sig_t pp_periph_out,
  input wire ebprb_pp_sig_t pp_periph_oe,
  output ebprb_pp_sig_t pp_periph_in,
  input wire logic [27:0] pp_pin_in,
  output logic [27:0] pp_pin_out,
  output logic [27:0] pp_pin_oe,
  input wire ebprb_sp1_sig_t sp1_periph_out,
  input wire ebprb_sp1_sig_t sp1_periph_oe,
  output ebprb_sp1_sig_t sp1_periph_in,
  input wire logic [5:0] sp1_pin_in,
  output logic [5:0] sp1_pin_out,
  output logic [5:0] sp1_pin_oe,
  input wire ebprb_sp0_sig_t sp0_periph_out,
  input wire ebprb_sp0_sig_t sp0_periph_oe,
  output ebprb_sp0_sig_t sp0_periph_in,
  input wire logic [5:0] sp0_pin_in,
  output logic [5:0] sp0_pin_out,
  output logic [5:0] sp0_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  ebprb_state_t state_r;
  ebprb_state_t state_nxt;
  logic sel_wr;
  logic sel_rd;
  logic boot_rd;
  logic [5:0] addr_mode;
  logic clk_choice;
  logic [2:0] pp_sel;
  logic [1:0] sp1_sel;
  logic [1:0] sp0_sel;

  assign sel_wr = io_cs && io_we && (io_addr == EBPRB_SEL_ADDR);
  assign sel_rd = io_cs && !io_we && (io_addr == EBPRB_SEL_ADDR);
  assign boot_rd = io_cs && !io_we && (io_addr == EBPRB_BOOT_ADDR);

  always_comb begin
    state_nxt = state_r;
    // R4 loader write path
    // R10 routing from register
    // R25 reserved bits masked
    if (sel_wr) begin
      state_nxt.sel = (io_wdata & EBPRB_SEL_WMASK) | (state_r.sel & ~EBPRB_SEL_WMASK);
    end
    // R2 strap capture delay
    case (state_r.boot)
      EBPRB_WAIT: begin
        if (state_r.cnt == EBPRB_BOOT_LATCH_CYCLES - 4'h2) begin
          state_nxt.boot = EBPRB_CAPTURE;
        end
        state_nxt.cnt = state_r.cnt + 4'h1;
      end
      EBPRB_CAPTURE: begin
        state_nxt.strap = ext_mem_addr_pins_in;
        state_nxt.boot = EBPRB_RUN;
      end
      EBPRB_RUN: begin
        state_nxt.boot = EBPRB_RUN;
      end
      default: begin
        state_nxt.boot = EBPRB_WAIT;
        state_nxt.cnt = 4'h0;
      end
    endcase
    // R6 memory clock off at hand-off
    if (loader_handoff) begin
      state_nxt.mem_clk_en = 1'b0;
    end else if (ext_mem_clk_request) begin
      state_nxt.mem_clk_en = 1'b1;
    end
    // R3 strap readback
    if (sel_rd) begin
      state_nxt.rdata = state_r.sel;
    end else if (boot_rd) begin
      state_nxt.rdata = {10'h000, state_r.strap};
    end else begin
      state_nxt.rdata = 16'h0000;
    end
  end

  // R22 register reset value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r.sel <= EBPRB_SEL_RESET;
      state_r.strap <= EBPRB_BOOT_RESET[5:0];
      state_r.cnt <= 4'h0;
      state_r.boot <= EBPRB_WAIT;
      state_r.mem_clk_en <= 1'b1;
      state_r.rdata <= 16'h0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign io_rdata = state_r.rdata;
  assign ext_mem_clk_en = state_r.mem_clk_en;
  assign boot_strap_done = (state_r.boot == EBPRB_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  assign addr_mode = state_r.sel[EBPRB_ADDR_MODE_LSB +: EBPRB_UPPER_PINS];
  assign clk_choice = state_r.sel[EBPRB_CLK_CHOICE_POS];
  assign pp_sel = state_r.sel[EBPRB_PP_LSB +: 3];
  assign sp1_sel = state_r.sel[EBPRB_SP1_LSB +: 2];
  assign sp0_sel = state_r.sel[EBPRB_SP0_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Upper address / general pins
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      // R1 inputs until captured
      if (!boot_strap_done) begin
        ext_mem_addr_pins_out[i] = 1'b0;
        ext_mem_addr_pins_oe[i] = 1'b0;
      // R11 per-pin function select
      end else if (addr_mode[i]) begin
        ext_mem_addr_pins_out[i] = upper_gpio_out[i];
        ext_mem_addr_pins_oe[i] = upper_gpio_oe[i];
      end else begin
        // R5 driven as address output
        ext_mem_addr_pins_out[i] = external_memory_if_addr_hi[i];
        ext_mem_addr_pins_oe[i] = 1'b1;
      end
    end
  end

  // Pin levels stay visible to general I/O in every mode
  assign upper_gpio_in = ext_mem_addr_pins_in;

  // R7 contiguous address reach
  always_comb begin
    logic stop;
    stop = 1'b0;
    ext_addr_width = 5'(EBPRB_LOW_ADDR_BITS);
    for (int i = 0; i < 6; i++) begin
      if (addr_mode[i]) begin
        stop = 1'b1;
      end else if (!stop) begin
        ext_addr_width = ext_addr_width + 5'h01;
      end
    end
  end

  // R8 SDRAM independent of upper pins
  // R15 host mode blocks SDRAM
  assign sdram_usable = (pp_sel != EBPRB_PP_HOST) && (pp_sel != EBPRB_PP_RSVD);

  ////////////////////////////////////////////////////////////////////////////
  // Parallel port lane maps
  logic [6:0][27:0] pp_lane_out;
  logic [6:0][27:0] pp_lane_oe;
  logic [6:0][27:0] pp_lane_in;

  function automatic logic [6:0][27:0] ebprb_pp_map(input ebprb_pp_sig_t s);
    logic [6:0][27:0] m;
    // R15 host port
    m[0] = s.host;
    // R16 mode 1
    m[1] = {s.sdram, s.aud2, s.uart, s.gpio[5:0], s.spi};
    // R17 mode 2
    m[2] = {s.sdram, 13'h0000, s.gpio};
    // R18 mode 3
    m[3] = {s.sdram, 13'h0000, s.aud3, s.spi[3:0]};
    // R19 mode 4
    m[4] = {s.sdram, 13'h0000, s.uart, s.aud2};
    // R20 mode 5
    m[5] = {s.sdram, 13'h0000, s.uart, s.spi[3:0]};
    // R21 mode 6
    m[6] = {s.sdram, s.aud3, s.aud2, s.gpio[5:0], s.spi};
    return m;
  endfunction

  assign pp_lane_out = ebprb_pp_map(pp_periph_out);
  assign pp_lane_oe = ebprb_pp_map(pp_periph_oe);

  // R9 parallel group select
  // R26 reserved code leaves pins idle
  ebprb_lane_mux #(
    .W(28),
    .NSRC(7),
    .SW(3)
  ) u_pp_mux (
    .sel(pp_sel),
    .lane_out(pp_lane_out),
    .lane_oe(pp_lane_oe),
    .pin_in(pp_pin_in),
    .pin_out(pp_pin_out),
    .pin_oe(pp_pin_oe),
    .lane_in(pp_lane_in)
  );

  // Inactive lanes read zero, so OR of all maps is the active one
  always_comb begin
    pp_periph_in = '0;
    pp_periph_in.host = pp_lane_in[0];
    pp_periph_in.sdram = pp_lane_in[1][27:21] | pp_lane_in[2][27:21] | pp_lane_in[3][27:21]
                       | pp_lane_in[4][27:21] | pp_lane_in[5][27:21] | pp_lane_in[6][27:21];
    pp_periph_in.spi = pp_lane_in[1][6:0] | pp_lane_in[6][6:0]
                     | {3'h0, pp_lane_in[3][3:0]} | {3'h0, pp_lane_in[5][3:0]};
    pp_periph_in.gpio = {2'h0, pp_lane_in[1][12:7]} | pp_lane_in[2][7:0] | {2'h0, pp_lane_in[6][12:7]};
    pp_periph_in.uart = pp_lane_in[1][16:13] | pp_lane_in[4][7:4] | pp_lane_in[5][7:4];
    pp_periph_in.aud2 = pp_lane_in[1][20:17] | pp_lane_in[4][3:0] | pp_lane_in[6][16:13];
    pp_periph_in.aud3 = pp_lane_in[3][7:4] | pp_lane_in[6][20:17];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port 1
  logic [2:0][5:0] sp1_lane_out;
  logic [2:0][5:0] sp1_lane_oe;
  logic [2:0][5:0] sp1_lane_in;

  // R23 serial port 1 modes
  assign sp1_lane_out = {sp1_periph_out.gpio, sp1_periph_out.mspi, sp1_periph_out.card};
  assign sp1_lane_oe = {sp1_periph_oe.gpio, sp1_periph_oe.mspi, sp1_periph_oe.card};

  ebprb_lane_mux #(
    .W(6),
    .NSRC(3),
    .SW(2)
  ) u_sp1_mux (
    .sel(sp1_sel),
    .lane_out(sp1_lane_out),
    .lane_oe(sp1_lane_oe),
    .pin_in(sp1_pin_in),
    .pin_out(sp1_pin_out),
    .pin_oe(sp1_pin_oe),
    .lane_in(sp1_lane_in)
  );

  assign sp1_periph_in = {sp1_lane_in[0], sp1_lane_in[1], sp1_lane_in[2]};

  ////////////////////////////////////////////////////////////////////////////
  // Serial port 0
  logic [3:0][5:0] sp0_lane_out;
  logic [3:0][5:0] sp0_lane_oe;
  logic [3:0][5:0] sp0_lane_in;

  // R24 serial port 0 modes
  // R14 shared clock lane choice
  always_comb begin
    sp0_lane_out[0] = sp0_periph_out.card;
    sp0_lane_oe[0] = sp0_periph_oe.card;
    sp0_lane_out[1] = {sp0_periph_out.gpio[5:4], sp0_periph_out.aud0};
    sp0_lane_oe[1] = {sp0_periph_oe.gpio[5:4], sp0_periph_oe.aud0};
    sp0_lane_out[2] = sp0_periph_out.gpio;
    sp0_lane_oe[2] = sp0_periph_oe.gpio;
    sp0_lane_out[3] = sp0_periph_out.bsp;
    sp0_lane_oe[3] = sp0_periph_oe.bsp;
    if (clk_choice) begin
      sp0_lane_out[3][5] = sp0_periph_out.bsp_sample;
      sp0_lane_oe[3][5] = sp0_periph_oe.bsp_sample;
    end
  end

  ebprb_lane_mux #(
    .W(6),
    .NSRC(4),
    .SW(2)
  ) u_sp0_mux (
    .sel(sp0_sel),
    .lane_out(sp0_lane_out),
    .lane_oe(sp0_lane_oe),
    .pin_in(sp0_pin_in),
    .pin_out(sp0_pin_out),
    .pin_oe(sp0_pin_oe),
    .lane_in(sp0_lane_in)
  );

  always_comb begin
    sp0_periph_in = '0;
    sp0_periph_in.card = sp0_lane_in[0];
    sp0_periph_in.aud0 = sp0_lane_in[1][3:0];
    sp0_periph_in.gpio = sp0_lane_in[2] | {sp0_lane_in[1][5:4], 4'h0};
    sp0_periph_in.bsp = sp0_lane_in[3];
    // R14 shared clock input side
    if (clk_choice) begin
      sp0_periph_in.bsp[5] = 1'b0;
      sp0_periph_in.bsp_sample = sp0_lane_in[3][5];
    end
  end

  // R12 clocks gated by software beforehand
  // R13 peripherals reset by software afterwards

endmodule
`default_nettype wire
